// [positioner_map.vh]
// register indices, status bit positions, reset values and timing for the parameter bank
// assumes inclusion by bare name from the design files of this block
`ifndef POSITIONER_MAP_VH
`define POSITIONER_MAP_VH
`define IDX_STATION_ALIAS 16'h2026
`define IDX_RANGE_UPPER_END 16'h2028
`define IDX_TORQUE_CAP 16'h202B
`define IDX_ROTATION_SENSE 16'h202C
`define IDX_REVERSAL_PAUSE 16'h202E
`define IDX_PRESENT_SPEED 16'h2030
`define IDX_RUN_PEAK_TORQUE 16'h2031
`define IDX_PRESENT_TORQUE 16'h2033
`define IDX_LOGIC_VOLTS 16'h203A
`define IDX_DRIVE_VOLTS 16'h203B
`define IDX_CONDITION_WORD 16'h2025
`define IDX_SAVE_PARAMS 16'h204F
`define BIT_RUNNING 6
`define BIT_ERROR 9
`define BIT_BLOCKED 10
`define BIT_HAND_MOVED 11
`define BIT_BAD_TARGET 12
`define BIT_POWER_WAS_LOST 13
`define BIT_POS_END 14
`define BIT_NEG_END 15
`define RST_STATION_ALIAS 16'h0000
`define RST_RANGE_UPPER_END 32'h00019000
`define RST_TORQUE_CAP 16'h0064
`define RST_ROTATION_SENSE 16'h0000
`define RST_REVERSAL_PAUSE 16'h000A
`define PAUSE_MIN_MS 16'h000A
`define PAUSE_MAX_MS 16'h2710
`define RANGE_MIN_REVS 32'h00000003
`define RANGE_MAX_REVS 32'h000000FD
`define CLK_MHZ 100
`define MS_NS 1000000
`define CLK_NS 10
`define CYCLES_PER_MS (`MS_NS / `CLK_NS)
`define SAVE_KEY 32'h65766173
`endif

// [ms_tick.v]
// one-cycle enable pulse every millisecond, derived from core_clk
// assumes a free-running core_clk at the rate set by the parameter
module ms_tick #(
  parameter CYCLES = 100000
) (
  input wire core_clk,
  input wire rst,
  output reg tick
);
  reg [16:0] cnt_q;
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt_q <= 17'h00000;
      tick <= 1'b0;
    end
    else if (cnt_q == CYCLES[16:0] - 17'h00001)
    begin
      cnt_q <= 17'h00000;
      tick <= 1'b1;
    end
    else
    begin
      cnt_q <= cnt_q + 17'h00001;
      tick <= 1'b0;
    end
  end
endmodule

// [peak_tracker.v]
// holds the largest torque seen in the cruise phase of the most recent run
// assumes the motion core flags the cruise phase for each sample
module peak_tracker #(
  parameter W = 16
) (
  input wire core_clk,
  input wire rst,
  input wire run_start,
  input wire cruise,
  input wire [W-1:0] torque,
  output reg [W-1:0] peak
);
  always @(posedge core_clk)
  begin
    if (rst)
      peak <= {W{1'b0}};
    else if (run_start)
      peak <= {W{1'b0}};
    else if (cruise && torque > peak)
      peak <= torque;
  end
endmodule

// [positioner_parameter_objects.v]
// parameter and status object bank of a motorised positioning drive
// assumes a service-object access port from the fieldbus stack, one access per strobe,
// and a motion core that supplies measurements and status events on core_clk
`include "positioner_map.vh"
module positioner_parameter_objects #(
  parameter CYCLES_PER_MS = `CYCLES_PER_MS,
  parameter [31:0] REV_INCREMENTS = 32'h00000400
) (
  input wire core_clk,
  input wire rst,
  input wire obj_req,
  input wire obj_wr,
  input wire [15:0] obj_index,
  input wire [31:0] obj_wdata,
  output reg obj_ack,
  output reg obj_err,
  output reg [31:0] obj_rdata,
  input wire [8:0] low_status,
  input wire ev_error,
  input wire ev_blocked,
  input wire ev_hand_moved,
  input wire ev_bad_target,
  input wire ev_power_lost,
  input wire at_pos_end,
  input wire at_neg_end,
  input wire status_clear,
  input wire [31:0] actual_position,
  input wire [15:0] speed_in,
  input wire [15:0] torque_in,
  input wire run_start,
  input wire cruise,
  input wire [15:0] logic_volts_in,
  input wire [15:0] drive_volts_in,
  input wire sii_alias_wr,
  input wire [15:0] sii_alias_data,
  input wire restart,
  input wire dir_request,
  input wire [15:0] hold_torque_in,
  output reg [15:0] active_alias,
  output reg nv_save,
  output reg [15:0] alias_to_save,
  output reg [31:0] range_end_out,
  output reg rotation_ccw,
  output reg [15:0] torque_limit,
  output reg move_permit
);
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function in_range16;
    input [15:0] v;
    input [15:0] lo;
    input [15:0] hi;
    begin
      in_range16 = (v >= lo) && (v <= hi);
    end
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  reg [15:0] alias_q;
  reg [15:0] saved_alias_q;
  reg [31:0] range_end_q;
  reg [15:0] torque_cap_q;
  reg rot_q;
  reg [15:0] pause_q;
  reg [6:0] sticky_q;
  reg [15:0] speed_q;
  reg [15:0] torque_q;
  reg [15:0] logic_v_q;
  reg [15:0] drive_v_q;
  reg [13:0] pause_cnt_q;
  reg pausing_q;
  reg last_dir_q;
  wire ms_en;
  wire [15:0] peak_w;
  wire [15:0] cond_word;
  wire standstill;
  wire [31:0] lo_end;
  wire [31:0] hi_end;
  wire wr;

  assign standstill = ~low_status[`BIT_RUNNING];
  assign cond_word = {sticky_q, low_status};
  assign lo_end = actual_position + REV_INCREMENTS * `RANGE_MIN_REVS;
  assign hi_end = actual_position + REV_INCREMENTS * `RANGE_MAX_REVS;
  assign wr = obj_req && obj_wr;

  ms_tick #(
    .CYCLES(CYCLES_PER_MS)
  ) u_tick (
    .core_clk(core_clk),
    .rst(rst),
    .tick(ms_en)
  );

  peak_tracker #(
    .W(16)
  ) u_peak (
    .core_clk(core_clk),
    .rst(rst),
    .run_start(run_start),
    .cruise(cruise),
    .torque(torque_in),
    .peak(peak_w)
  );

  // ----------------------------------------------------------------
  // status flags, bits 9 to 15: bits 9 to 13 sticky, bits 14 and 15 follow the range-end inputs
  // ----------------------------------------------------------------
  // an event in the clearing cycle survives: set wins
  always @(posedge core_clk)
  begin
    if (rst)
      sticky_q <= 7'h00;
    else
    begin
      sticky_q[0] <= ev_error | (sticky_q[0] & ~status_clear);
      sticky_q[1] <= ev_blocked | (sticky_q[1] & ~status_clear);
      sticky_q[2] <= ev_hand_moved | (sticky_q[2] & ~status_clear);
      sticky_q[3] <= ev_bad_target | (sticky_q[3] & ~status_clear);
      sticky_q[4] <= ev_power_lost | (sticky_q[4] & ~status_clear);
      sticky_q[5] <= at_pos_end;
      sticky_q[6] <= at_neg_end;
    end
  end

  // ----------------------------------------------------------------
  // measurements, sampled each cycle, never written by the bus
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      speed_q <= 16'h0000;
      torque_q <= 16'h0000;
      logic_v_q <= 16'h0000;
      drive_v_q <= 16'h0000;
    end
    else
    begin
      speed_q <= speed_in;
      torque_q <= torque_in;
      logic_v_q <= logic_volts_in;
      drive_v_q <= drive_volts_in;
    end
  end

  // ----------------------------------------------------------------
  // object access
  // ----------------------------------------------------------------
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      obj_ack <= 1'b0;
      obj_err <= 1'b0;
      obj_rdata <= 32'h00000000;
      alias_q <= `RST_STATION_ALIAS;
      range_end_q <= `RST_RANGE_UPPER_END;
      torque_cap_q <= `RST_TORQUE_CAP;
      rot_q <= 1'b0;
      pause_q <= `RST_REVERSAL_PAUSE;
      nv_save <= 1'b0;
      saved_alias_q <= `RST_STATION_ALIAS;
    end
    else
    begin
      obj_ack <= obj_req;
      obj_err <= 1'b0;
      obj_rdata <= 32'h00000000;
      nv_save <= 1'b0;
      if (sii_alias_wr)
      begin
        // the store was written directly, so commit without waiting for the master
        alias_q <= sii_alias_data;
        saved_alias_q <= sii_alias_data;
        nv_save <= 1'b1;
      end
      if (obj_req)
      begin
        case (obj_index)
          `IDX_STATION_ALIAS:
          begin
            obj_rdata <= {16'h0000, alias_q};
            if (obj_wr)
              alias_q <= obj_wdata[15:0];
          end
          `IDX_RANGE_UPPER_END:
          begin
            obj_rdata <= range_end_q;
            if (obj_wr)
            begin
              if (standstill && obj_wdata >= lo_end && obj_wdata <= hi_end)
                range_end_q <= obj_wdata;
              else
                obj_err <= 1'b1;
            end
          end
          `IDX_TORQUE_CAP:
          begin
            obj_rdata <= {16'h0000, torque_cap_q};
            if (obj_wr)
              torque_cap_q <= obj_wdata[15:0];
          end
          `IDX_ROTATION_SENSE:
          begin
            obj_rdata <= {31'h00000000, rot_q};
            if (obj_wr)
            begin
              if (standstill && obj_wdata[31:1] == 31'h00000000)
                rot_q <= obj_wdata[0];
              else
                obj_err <= 1'b1;
            end
          end
          `IDX_REVERSAL_PAUSE:
          begin
            obj_rdata <= {16'h0000, pause_q};
            if (obj_wr)
            begin
              if (obj_wdata[31:16] == 16'h0000 &&
                  in_range16(obj_wdata[15:0], `PAUSE_MIN_MS, `PAUSE_MAX_MS))
                pause_q <= obj_wdata[15:0];
              else
                obj_err <= 1'b1;
            end
          end
          `IDX_SAVE_PARAMS:
          begin
            if (obj_wr)
            begin
              if (obj_wdata == `SAVE_KEY)
              begin
                saved_alias_q <= alias_q;
                nv_save <= 1'b1;
              end
              else
                obj_err <= 1'b1;
            end
          end
          `IDX_PRESENT_SPEED:
          begin
            obj_rdata <= {16'h0000, speed_q};
            obj_err <= obj_wr;
          end
          `IDX_RUN_PEAK_TORQUE:
          begin
            obj_rdata <= {16'h0000, peak_w};
            obj_err <= obj_wr;
          end
          `IDX_PRESENT_TORQUE:
          begin
            obj_rdata <= {16'h0000, torque_q};
            obj_err <= obj_wr;
          end
          `IDX_LOGIC_VOLTS:
          begin
            obj_rdata <= {16'h0000, logic_v_q};
            obj_err <= obj_wr;
          end
          `IDX_DRIVE_VOLTS:
          begin
            obj_rdata <= {16'h0000, drive_v_q};
            obj_err <= obj_wr;
          end
          `IDX_CONDITION_WORD:
          begin
            obj_rdata <= {16'h0000, cond_word};
            obj_err <= obj_wr;
          end
          default:
            obj_err <= 1'b1;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // address take-over on restart
  // ----------------------------------------------------------------
  // the live alias only moves on restart, from the saved copy
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      active_alias <= `RST_STATION_ALIAS;
      alias_to_save <= `RST_STATION_ALIAS;
    end
    else
    begin
      alias_to_save <= saved_alias_q;
      if (restart)
        active_alias <= saved_alias_q;
    end
  end

  // ----------------------------------------------------------------
  // reversal pause and drive-facing outputs
  // ----------------------------------------------------------------
  // limitation: pause counts whole ms ticks, so it may be up to 1 ms short of a tick boundary
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      pause_cnt_q <= 14'h0000;
      pausing_q <= 1'b0;
      last_dir_q <= 1'b0;
      move_permit <= 1'b1;
      range_end_out <= `RST_RANGE_UPPER_END;
      rotation_ccw <= 1'b0;
      torque_limit <= 16'h0000;
    end
    else
    begin
      range_end_out <= range_end_q;
      rotation_ccw <= rot_q;
      // holding torque clipped to the cap only at standstill
      if (standstill && hold_torque_in > torque_cap_q)
        torque_limit <= torque_cap_q;
      else
        torque_limit <= hold_torque_in;
      if (!pausing_q && dir_request != last_dir_q)
      begin
        pausing_q <= 1'b1;
        pause_cnt_q <= pause_q[13:0];
        move_permit <= 1'b0;
        last_dir_q <= dir_request;
      end
      else if (pausing_q && ms_en)
      begin
        if (pause_cnt_q <= 14'h0001)
        begin
          pausing_q <= 1'b0;
          move_permit <= 1'b1;
        end
        else
          pause_cnt_q <= pause_cnt_q - 14'h0001;
      end
    end
  end
endmodule

// [positioner_parameter_objects_props.sv]
// concurrent checks on the ports of the object bank
// assumes the bank's top module exposes the object port and status inputs
module positioner_parameter_objects_props (
  input wire core_clk,
  input wire rst,
  input wire obj_req,
  input wire obj_wr,
  input wire [15:0] obj_index,
  input wire [31:0] obj_wdata,
  input wire obj_ack,
  input wire obj_err,
  input wire [8:0] low_status,
  input wire at_pos_end,
  input wire [31:0] obj_rdata,
  input wire restart,
  input wire sii_alias_wr,
  input wire [15:0] active_alias,
  input wire nv_save
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  wire wr = obj_req && obj_wr;
  wire pz = wr && obj_index == 16'h202E;
  ack_after_req_a: assert property (obj_req |=> obj_ack)
    else $error("no answer one cycle after a request");
  ack_has_cause_a: assert property (obj_ack |-> $past(obj_req))
    else $error("answer without a request");
  ro_write_refused_a: assert property (wr && obj_index inside {16'h2025, 16'h2030,
    16'h2031, 16'h2033, 16'h203A, 16'h203B} |=> obj_err) else $error("read-only write taken");
  moving_write_refused_a: assert property (wr && low_status[6] &&
    obj_index inside {16'h2028, 16'h202C} |=> obj_err) else $error("write taken while moving");
  sense_range_a: assert property (wr && obj_index == 16'h202C && obj_wdata > 1 |=> obj_err)
    else $error("bad rotation sense taken");
  pause_refused_a: assert property (pz && (obj_wdata < 10 || obj_wdata > 10000) |=> obj_err)
    else $error("bad pause taken");
  pause_taken_a: assert property (pz && obj_wdata >= 10 && obj_wdata <= 10000 |=> !obj_err)
    else $error("good pause refused");
  pos_end_bit_a: assert property (obj_req && !obj_wr && obj_index == 16'h2025 && at_pos_end
    && $past(at_pos_end) && !$past(rst) |=> obj_rdata[14]) else $error("range end bit missing");
  alias_held_a: assert property (!restart |=> $stable(active_alias))
    else $error("live alias moved without restart");
  save_pulse_a: assert property (wr && obj_index == 16'h204F && obj_wdata == 32'h65766173
    |=> nv_save) else $error("no save after key");
  store_save_a: assert property (sii_alias_wr |-> ##[1:3] nv_save)
    else $error("no save after store write");
  cover property (wr ##1 obj_err);
  cover property (nv_save);
  cover property (restart ##1 active_alias != 16'h0000);
endmodule
bind positioner_parameter_objects positioner_parameter_objects_props
  positioner_parameter_objects_props_inst (.*);

// [sdo_master.sv]
// behavioural fieldbus master issuing one object access per strobe
// assumes the bank answers exactly one cycle after the strobe is taken
module sdo_master (
  input wire core_clk,
  input wire obj_ack,
  input wire obj_err,
  input wire [31:0] obj_rdata,
  output logic obj_req,
  output logic obj_wr,
  output logic [15:0] obj_index,
  output logic [31:0] obj_wdata
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    obj_req = 1'b0;
    obj_wr = 1'b0;
    obj_index = 16'h0000;
    obj_wdata = 32'h00000000;
  end
  // a save request is just a keyed write to the save object
  task xfer(input logic w, input logic [15:0] i, input logic [31:0] d,
    output logic [31:0] r, output logic e, output logic a);
    @(negedge core_clk);
    obj_req = 1'b1;
    obj_wr = w;
    obj_index = i;
    obj_wdata = d;
    @(negedge core_clk);
    // released lines show garbage, not the last value
    obj_req = 1'b0;
    obj_wr = ~w;
    obj_index = ~i;
    obj_wdata = ~d;
    a = obj_ack;
    r = obj_rdata;
    e = obj_err;
  endtask
endmodule

// [positioner_parameter_objects_tb_top.sv]
// self-checking bench: master model plus a reference model of the object values
// assumes the checker is bound from its own file
module positioner_parameter_objects_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic obj_req, obj_wr, obj_ack, obj_err, e, a, nv_save, ccw, mp;
  logic [15:0] obj_index, speed_in, torque_in, lv, dv, sii_d, al, active_alias, tl, ats, ht;
  logic [31:0] obj_wdata, obj_rdata, r, pos, reo;
  logic [8:0] low_status = 9'h000;
  // pulse lines: 0..4 status events, 5 clear, 6 run start, 7 store write, 8 restart
  logic [8:0] pl = 9'h000;
  logic pe = 0, ne = 0, cr = 0, dir = 0;
  logic [31:0] m [logic [15:0]];
  logic [15:0] ro [6] = '{16'h2025, 16'h2030, 16'h2031, 16'h2033, 16'h203A, 16'h203B};
  int err_count = 0, tests_run = 0, cyc = 0, peak = 0;
  always #5 core_clk = ~core_clk;
  positioner_parameter_objects #(.CYCLES_PER_MS(4)) positioner_parameter_objects_inst (
    .core_clk(core_clk), .rst(rst), .obj_req(obj_req), .obj_wr(obj_wr),
    .obj_index(obj_index), .obj_wdata(obj_wdata), .obj_ack(obj_ack), .obj_err(obj_err),
    .obj_rdata(obj_rdata), .low_status(low_status), .ev_error(pl[0]), .ev_blocked(pl[1]),
    .ev_hand_moved(pl[2]), .ev_bad_target(pl[3]), .ev_power_lost(pl[4]), .at_pos_end(pe),
    .at_neg_end(ne), .status_clear(pl[5]), .actual_position(pos), .speed_in(speed_in),
    .torque_in(torque_in), .run_start(pl[6]), .cruise(cr), .logic_volts_in(lv),
    .drive_volts_in(dv), .sii_alias_wr(pl[7]), .sii_alias_data(sii_d), .restart(pl[8]),
    .dir_request(dir), .hold_torque_in(ht), .active_alias(active_alias),
    .nv_save(nv_save), .alias_to_save(ats), .range_end_out(reo), .rotation_ccw(ccw),
    .torque_limit(tl), .move_permit(mp));
  sdo_master sdo_master_inst (.core_clk(core_clk), .obj_ack(obj_ack), .obj_err(obj_err),
    .obj_rdata(obj_rdata), .obj_req(obj_req), .obj_wr(obj_wr), .obj_index(obj_index),
    .obj_wdata(obj_wdata));
  task chk(input logic [31:0] g, input logic [31:0] x);
    tests_run++;
    if (g !== x)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  task report_and_stop;
    $display("checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // x unknown means the returned data is not predicted
  task acc(input logic w, input logic [15:0] i, input logic [31:0] d,
    input logic [31:0] x, input logic xe);
    sdo_master_inst.xfer(w, i, d, r, e, a);
    chk(a, 1'b1);
    chk(e, xe);
    if (!xe && !$isunknown(x))
      chk(r, x);
  endtask
  task wr(input logic [15:0] i, input logic [31:0] d, input logic ok);
    acc(1'b1, i, d, m[i], !ok);
    if (ok)
      m[i] = d;
  endtask
  // drives the module-level line itself: a by-value argument would never reach the pin
  task pulse(input int k);
    @(negedge core_clk) pl[k] = 1'b1;
    @(negedge core_clk) pl[k] = 1'b0;
  endtask
  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      report_and_stop();
    end
  end
  initial
  begin
    void'($urandom(71));
    {speed_in, lv, dv, al} = {$urandom, $urandom | 32'h1};
    torque_in = 16'h0000;
    ht = 16'hFFFF;
    // odd mask flips bit 0, so the store value always differs from the object value
    sii_d = al ^ 16'($urandom | 32'h1);
    pos = $urandom & 32'h000FFFFF;
    m[16'h2026] = 0;
    m[16'h2028] = 32'h00019000;
    m[16'h202B] = 32'h64;
    m[16'h202C] = 0;
    m[16'h202E] = 32'hA;
    repeat (10) @(negedge core_clk);
    rst = 1'b0;
    low_status = 9'($urandom) & 9'h1BF;
    foreach (m[k]) acc(1'b0, k, 0, m[k], 1'b0);
    acc(1'b0, 16'h2030, 0, speed_in, 1'b0);
    acc(1'b0, 16'h203A, 0, lv, 1'b0);
    acc(1'b0, 16'h203B, 0, dv, 1'b0);
    foreach (ro[j]) acc(1'b1, ro[j], $urandom, 'x, 1'b1);
    acc(1'b0, 16'h203B, 0, dv, 1'b0);
    acc(1'b1, 16'h2027, 0, 'x, 1'b1);
    wr(16'h202E, 9, 0);
    wr(16'h202E, 10001, 0);
    wr(16'h202E, 10000, 1);
    wr(16'h202E, 10, 1);
    wr(16'h202C, 2, 0);
    wr(16'h202C, 1, 1);
    @(negedge core_clk) chk(ccw, 1'b1);
    dir = 1'b1;
    // 10 ms pause at 4 cycles per ms, at most 1 ms short
    repeat (2) @(negedge core_clk);
    chk(mp, 1'b0);
    repeat (34) @(negedge core_clk);
    chk(mp, 1'b0);
    repeat (6) @(negedge core_clk);
    chk(mp, 1'b1);
    low_status[6] = 1'b1;
    wr(16'h202C, 0, 0);
    wr(16'h2028, pos + 32'h1400, 0);
    low_status[6] = 1'b0;
    wr(16'h2028, pos + 32'hBFF, 0);
    wr(16'h2028, pos + 32'h3F401, 0);
    wr(16'h2028, pos + 32'hC00, 1);
    wr(16'h2028, pos + 32'h3F400, 1);
    @(negedge core_clk) chk(reo, m[16'h2028]);
    wr(16'h202B, $urandom & 32'hFFFE, 1);
    @(negedge core_clk) chk(tl, m[16'h202B]);
    ht = 16'h0000;
    @(negedge core_clk) chk(tl, 32'h0);
    for (int j = 0; j < 5; j++)
    begin
      pulse(j);
      acc(1'b0, 16'h2025, 0, (((2 << j) - 1) << 9) | low_status, 1'b0);
    end
    pe = 1'b1;
    ne = 1'b1;
    pulse(5);
    pulse(5);
    acc(1'b0, 16'h2025, 0, 32'hC000 | low_status, 1'b0);
    pe = 1'b0;
    ne = 1'b0;
    wr(16'h2026, al, 1);
    chk(active_alias, 16'h0000);
    acc(1'b1, 16'h204F, 32'h1, 'x, 1'b1);
    acc(1'b1, 16'h204F, 32'h65766173, 'x, 1'b0);
    chk(active_alias, 16'h0000);
    pulse(8);
    chk(active_alias, al);
    chk(ats, al);
    pulse(7);
    m[16'h2026] = sii_d;
    acc(1'b0, 16'h2026, 0, sii_d, 1'b0);
    chk(active_alias, al);
    pulse(6);
    cr = 1'b1;
    repeat (4)
    begin
      @(negedge core_clk) torque_in = 16'($urandom) & 16'h7FFF;
      peak = (torque_in > peak) ? torque_in : peak;
    end
    @(negedge core_clk) cr = 1'b0;
    torque_in = 16'hFFFF;
    acc(1'b0, 16'h2031, 0, peak, 1'b0);
    acc(1'b0, 16'h2033, 0, torque_in, 1'b0);
    foreach (m[k]) acc(1'b0, k, 0, m[k], 1'b0);
    report_and_stop();
  end
endmodule
